// file: flp_drv_model.sv
`timescale 1ns/1ns
`default_nettype none
module flp_drv_model
#(
	parameter int TRIM  = 300,
	parameter bit PSAVE = 1'b1
)(
	// clock and media
	input  wire logic                 clk_i,
	input  wire logic                 protect_i,
	// cable
	input  wire flp_pkg::flp_drv_out_t pins_i,
	output flp_pkg::flp_drv_in_t      pins_o,
	// observation
	output logic [7:0]                track_o,
	output logic [7:0]                wave_o
);
	import flp_pkg::*;
	logic       sel, gate, busy;
	logic       trim     = 1'b0;
	logic       gate_q   = 1'b0;
	logic       sel_seen = 1'b0;
	logic [1:0] phase    = 2'h0;
	int         tc       = 0;
	int         cyc      = 0;
	initial track_o = 8'h00;
	initial wave_o = 8'h00;
	assign sel  = !pins_i.unit_pick_n[0];
	assign gate = sel && !pins_i.record_gate_n && !protect_i;
	assign busy = gate || trim;
	always @(posedge clk_i)
	begin
		gate_q <= gate;
		tc     <= (gate != gate_q) ? 0 : tc + 1;
		if (tc == TRIM)
			trim <= gate_q;
		cyc    <= cyc + 1;
		if (sel)
			sel_seen <= 1'b1;
	end
	always @(negedge pins_i.track_advance_pulse_n)
		if (sel && !busy && !pins_i.seek_sense_n)
		begin
			track_o <= track_o + 8'h01;
			phase   <= phase + 2'h1;
		end
		else if (sel && !busy && (track_o != 8'h00 || phase != 2'h0))
		begin
			track_o <= track_o - 8'(track_o != 8'h00);
			phase   <= phase - 2'h1;
		end
	always @(posedge pins_i.unit_pick_n[0])
		if (PSAVE && sel_seen)
			phase <= 2'h2;
	always @(negedge pins_i.record_flux_n)
		if (gate)
			wave_o <= wave_o + 8'h01;
	assign pins_o = {!(sel && !pins_i.motor_on_n && cyc % 500 < 4),
		!(sel && track_o == 8'h00 && phase == 2'h0), !(sel && protect_i),
		!(sel && !pins_i.motor_on_n && !busy && cyc % 60 < 25)};
endmodule
`default_nettype wire

// file: flp_host.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module flp_host
	import flp_pkg::*;
#(
	parameter int SPIN_CYC   = flp_pkg::SPIN_CYC_DEF,
	parameter int SETTLE_CYC = flp_pkg::SETTLE_CYC_DEF,
	parameter int STEP_GAP   = flp_pkg::STEP_GAP_DEF,
	parameter int TRIM_CYC   = flp_pkg::TRIM_CYC_DEF
)(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// drive pins
	output flp_pkg::flp_drv_out_t   drv_o,
	input  wire flp_pkg::flp_drv_in_t drv_i
);
	import flp_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	flp_state_t st_q;
	flp_state_t st_d;

	logic wb_req;
	logic wr_ok;
	logic stepping;
	logic writing;
	logic ready;
	logic read_ok;
	logic home;
	logic locked;
	logic [3:0] pick;

	// wishbone request, one access per ack
	assign wb_req   = wb_cyc_i && wb_stb_i && !st_q.ack;
	assign wr_ok    = wb_req && wb_we_i && wb_sel_i[0];
	assign stepping = (st_q.steps != 7'h0) || (st_q.step_w != 8'h00);
	assign writing  = !st_q.pins.record_gate_n || (st_q.tail != FLP_TAIL_NONE);
	// spin and settle overlap; ready only when both are over
	assign ready    = st_q.spin_ok && (st_q.settle_cnt == 24'h00_0000) &&
		!stepping;
	assign read_ok  = ready && !writing && (st_q.rec_cnt == 24'h00_0000);
	// synchronised status lines, low means true
	assign home     = !st_q.sy2[2];
	assign locked   = !st_q.sy2[1];
	assign pick     = st_q.ctrl[CTRL_UEN] ?
		~(4'h1 << st_q.ctrl[CTRL_UNIT +: 2]) : 4'hF;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_d     = st_q;
		st_d.ack = wb_req;
		// pins cross from the drive's domain through two stages
		st_d.sy1 = drv_i;
		st_d.sy2 = st_q.sy1;
		st_d.sy3 = st_q.sy2;

		// register writes
		if (wr_ok && wb_adr_i == REG_CTRL)
		begin
			st_d.ctrl = wb_dat_i[7:0];
		end
		// sense set now, first pulse no earlier than next cycle
		if (wr_ok && wb_adr_i == REG_SEEK && !stepping && !writing)
		begin
			st_d.steps             = wb_dat_i[6:0];
			st_d.pins.seek_sense_n = !wb_dat_i[SEEK_DIR];
		end
		if (wr_ok && wb_adr_i == REG_FLUX)
		begin
			st_d.flux_pend = 1'b1;
		end

		// motor line follows the control bit
		st_d.pins.motor_on_n = !st_q.ctrl[CTRL_MOTOR];

		// spin-up wait restarts whenever the motor is off
		if (st_q.pins.motor_on_n)
		begin
			st_d.spin_cnt = 24'h00_0000;
			st_d.spin_ok  = 1'b0;
		end
		else if (!st_q.spin_ok)
		begin
			st_d.spin_cnt = st_q.spin_cnt + 24'h00_0001;
			st_d.spin_ok  = (st_q.spin_cnt == 24'(SPIN_CYC - 1));
		end

		// home seen clears recal; a reselect below still sets it
		if (home)
		begin
			st_d.recal = 1'b0;
		end
		// select and head only change while nothing is in flight
		if (!stepping && !writing)
		begin
			st_d.pins.unit_pick_n   = pick;
			st_d.pins.head_choice_n = !st_q.ctrl[CTRL_HEAD];
			// reselect under power save loses the track position
			if (st_q.ctrl[CTRL_PSAVE] && pick != 4'hF &&
				pick != st_q.pins.unit_pick_n)
			begin
				st_d.recal = 1'b1;
			end
		end

		// step engine, spaced by the motion time
		if (st_q.gap_cnt != 24'h00_0000)
		begin
			st_d.gap_cnt = st_q.gap_cnt - 24'h00_0001;
		end
		if (st_q.settle_cnt != 24'h00_0000)
		begin
			st_d.settle_cnt = st_q.settle_cnt - 24'h00_0001;
		end
		if (st_q.step_w != 8'h00)
		begin
			st_d.step_w = st_q.step_w - 8'h01;
		end
		// step pulses held off during any write
		else if (st_q.steps != 7'h0 && st_q.gap_cnt == 24'h00_0000 &&
			!writing)
		begin
			st_d.steps      = st_q.steps - 7'h1;
			st_d.step_w     = 8'(STEP_W_CYC);
			st_d.gap_cnt    = 24'(STEP_GAP);
			// settle counted from the start of each pulse
			st_d.settle_cnt = 24'(SETTLE_CYC);
		end

		// read recovery after write busy ends
		if (st_q.rec_cnt != 24'h00_0000)
		begin
			st_d.rec_cnt = st_q.rec_cnt - 24'h00_0001;
		end
		if (st_q.first_cnt != 8'h00)
		begin
			st_d.first_cnt = st_q.first_cnt - 8'h01;
		end
		if (st_q.flux_w != 8'h00)
		begin
			st_d.flux_w = st_q.flux_w - 8'h01;
		end

		// gate opens only on a ready, unlocked drive
		if (st_q.ctrl[CTRL_WREQ] && st_q.pins.record_gate_n && ready &&
			!locked && st_q.tail == FLP_TAIL_NONE)
		begin
			st_d.pins.record_gate_n = 1'b0;
			st_d.first_cnt          = 8'(FIRST_MIN_CYC);
		end
		else if (!st_q.pins.record_gate_n)
		begin
			// dropping the request queues one extra pulse
			if (!st_q.ctrl[CTRL_WREQ] && st_q.tail == FLP_TAIL_NONE)
			begin
				st_d.tail = FLP_TAIL_PEND;
			end
			// no flux pulse before the first-pulse window opens
			if (st_q.first_cnt == 8'h00 && st_q.flux_w == 8'h00)
			begin
				// queued pulses go before the tail, so none is lost
				if (st_q.flux_pend)
				begin
					st_d.flux_w    = 8'(FLUX_W_CYC);
					st_d.flux_pend = wr_ok && wb_adr_i == REG_FLUX;
				end
				else if (st_q.tail == FLP_TAIL_PEND)
				begin
					st_d.flux_w = 8'(FLUX_W_CYC);
					st_d.tail   = FLP_TAIL_SENT;
				end
				else if (st_q.tail == FLP_TAIL_SENT)
				begin
					// busy runs on until trim erase ends
					st_d.pins.record_gate_n = 1'b1;
					st_d.tail               = FLP_TAIL_NONE;
					st_d.rec_cnt = 24'(TRIM_CYC) + 24'(RECOV_CYC);
				end
			end
		end
		// pulses queued outside a write are dropped
		if (st_q.pins.record_gate_n && st_q.tail == FLP_TAIL_NONE)
		begin
			st_d.flux_pend = 1'b0;
		end

		// pulse lines as registered copies of their counters
		st_d.pins.track_advance_pulse_n = (st_d.step_w == 8'h00);
		st_d.pins.record_flux_n         = (st_d.flux_w == 8'h00);

		// read peaks counted on falling edge, only when readable
		if (!st_q.sy2[0] && st_q.sy3[0] && read_ok)
		begin
			st_d.rd_cnt = st_q.rd_cnt + 16'h0001;
		end
		// index holes counted on falling edge
		if (!st_q.sy2[3] && st_q.sy3[3])
		begin
			st_d.ix_cnt = st_q.ix_cnt + 16'h0001;
		end

		// register reads, unmapped reads answer zero
		st_d.dat = 32'h0000_0000;
		case (wb_adr_i)
			REG_CTRL: st_d.dat[7:0] = st_q.ctrl;
			REG_SEEK: st_d.dat[7:0] = {!st_q.pins.seek_sense_n, st_q.steps};
			REG_STAT: st_d.dat[9:0] = {st_q.flux_pend, st_q.recal, locked,
				home, stepping, writing, read_ok, ready,
				(st_q.settle_cnt == 24'h00_0000), st_q.spin_ok};
			REG_CNT:  st_d.dat = {st_q.ix_cnt, st_q.rd_cnt};
			default:  st_d.dat = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q      <= '0;
			st_q.ctrl <= CTRL_RST;
			st_q.pins <= DRV_IDLE;
			st_q.sy1  <= 4'hF;
			st_q.sy2  <= 4'hF;
			st_q.sy3  <= 4'hF;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// every pin driven high when idle, low when true
	assign drv_o    = st_q.pins;
	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.dat;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_flux_pulse;
		!drv_o.record_flux_n [*5] ##1 drv_o.record_flux_n;
	endsequence

	property p_motor;
		st_q.ctrl[CTRL_MOTOR] |=> !drv_o.motor_on_n;
	endproperty
	a_motor: assert property (p_motor) else $error("motor line wrong");

	property p_spin;
		drv_o.motor_on_n |=> !st_q.spin_ok;
	endproperty
	a_spin: assert property (p_spin) else $error("spin ok with motor off");

	property p_no_step_write;
		!drv_o.record_gate_n |-> drv_o.track_advance_pulse_n;
	endproperty
	a_no_step_write: assert property (p_no_step_write)
		else $error("step during write");

	property p_settle;
		$fell(drv_o.track_advance_pulse_n) |-> !ready [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("ready after step");

	property p_sense;
		!drv_o.track_advance_pulse_n |-> $stable(drv_o.seek_sense_n);
	endproperty
	a_sense: assert property (p_sense) else $error("sense moved in pulse");

	property p_first;
		$fell(drv_o.record_gate_n) |-> drv_o.record_flux_n [*8];
	endproperty
	a_first: assert property (p_first) else $error("flux too early");

	property p_tail;
		$rose(drv_o.record_gate_n) |-> $past(st_q.tail) == FLP_TAIL_SENT;
	endproperty
	a_tail: assert property (p_tail) else $error("no tail pulse");

	property p_tail_seq;
		(!drv_o.record_gate_n && st_q.tail == FLP_TAIL_PEND &&
			st_q.flux_w == 8'h00 && st_q.first_cnt == 8'h00)
			|=> s_flux_pulse;
	endproperty
	a_tail_seq: assert property (p_tail_seq)
		else $error("tail pulse missing");

	property p_one_pick;
		$countones(~drv_o.unit_pick_n) <= 1;
	endproperty
	a_one_pick: assert property (p_one_pick) else $error("two selects");

	property p_pick_stable;
		(!drv_o.record_gate_n || stepping) |=> $stable(drv_o.unit_pick_n);
	endproperty
	a_pick_stable: assert property (p_pick_stable)
		else $error("select moved while busy");

	property p_recov;
		$rose(drv_o.record_gate_n) |-> !read_ok [*8];
	endproperty
	a_recov: assert property (p_recov) else $error("read too soon");

	property p_locked;
		(locked && drv_o.record_gate_n) |=> drv_o.record_gate_n;
	endproperty
	a_locked: assert property (p_locked) else $error("write on lock");

endmodule
`default_nettype wire

// file: flp_pkg.sv
`default_nettype none
package flp_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_KHZ        = 25000;
	localparam int SPIN_MS        = 250;   // spindle speed stabilisation
	localparam int SETTLE_MS      = 18;    // last step to data access
	localparam int STEP_MOVE_MS   = 3;     // step motion, used as step spacing
	localparam int TRIM_MS        = 390;   // gate to trim erase delay
	localparam int RECOV_US       = 100;   // read amp settle after trim erase
	localparam int FIRST_MIN_US   = 4;     // earliest first flux pulse
	localparam int FIRST_MAX_US   = 8;     // latest first flux pulse
	localparam int STEP_W_NS      = 1000;  // step pulse width
	localparam int FLUX_W_NS      = 200;   // flux pulse width

	localparam int SPIN_CYC_DEF   = SPIN_MS * CLK_KHZ;
	localparam int SETTLE_CYC_DEF = SETTLE_MS * CLK_KHZ;
	localparam int STEP_GAP_DEF   = STEP_MOVE_MS * CLK_KHZ;
	localparam int TRIM_CYC_DEF   = TRIM_MS * CLK_KHZ;
	localparam int RECOV_CYC      = (RECOV_US * CLK_KHZ + 999) / 1000;
	localparam int FIRST_MIN_CYC  = (FIRST_MIN_US * CLK_KHZ + 999) / 1000;
	localparam int FIRST_MAX_CYC  = (FIRST_MAX_US * CLK_KHZ) / 1000;
	localparam int STEP_W_CYC     = (STEP_W_NS * CLK_KHZ / 1000 + 999) / 1000;
	localparam int FLUX_W_CYC     = (FLUX_W_NS * CLK_KHZ / 1000 + 999) / 1000;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SEEK = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_FLUX = 8'h0C;
	localparam logic [7:0] REG_CNT  = 8'h10;

	// control and seek register fields
	localparam int CTRL_MOTOR  = 0;
	localparam int CTRL_UNIT   = 1;   // two bits
	localparam int CTRL_UEN    = 3;
	localparam int CTRL_HEAD   = 4;
	localparam int CTRL_WREQ   = 5;
	localparam int CTRL_PSAVE  = 6;
	localparam int SEEK_DIR    = 7;   // 1 = inward
	localparam logic [7:0] CTRL_RST = 8'h00_00;

	// tail pulse phases
	typedef enum logic [1:0] {
		FLP_TAIL_NONE = 2'b00,
		FLP_TAIL_PEND = 2'b01,
		FLP_TAIL_SENT = 2'b10
	} flp_tail_t;

	// drive pins, all active low
	typedef struct packed {
		logic [3:0] unit_pick_n;
		logic       motor_on_n;
		logic       seek_sense_n;
		logic       track_advance_pulse_n;
		logic       record_flux_n;
		logic       record_gate_n;
		logic       head_choice_n;
	} flp_drv_out_t;

	typedef struct packed {
		logic hole_pulse_n;
		logic home_track_flag_n;
		logic media_locked_n;
		logic playback_pulse_n;
	} flp_drv_in_t;

	localparam flp_drv_out_t DRV_IDLE = '1;

	// controller state, registered as one word
	typedef struct packed {
		logic [7:0]   ctrl;
		flp_drv_out_t pins;
		logic [6:0]   steps;
		logic [23:0]  spin_cnt;
		logic         spin_ok;
		logic [23:0]  settle_cnt;
		logic [23:0]  gap_cnt;
		logic [7:0]   step_w;
		logic [7:0]   flux_w;
		logic [7:0]   first_cnt;
		logic [23:0]  rec_cnt;
		logic         flux_pend;
		flp_tail_t    tail;
		logic         recal;
		logic [3:0]   sy1;
		logic [3:0]   sy2;
		logic [3:0]   sy3;
		logic [15:0]  rd_cnt;
		logic [15:0]  ix_cnt;
		logic         ack;
		logic [31:0]  dat;
	} flp_state_t;

endpackage
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import flp_pkg::*;
	// ----------------------------------------
	// clock, bus and drive
	// ----------------------------------------
	localparam int SPIN = 200, SETTLE = 100, GAP = 40, TRIM = 300;
	typedef struct packed
	{
		logic w; logic [7:0] a; logic [3:0] s; logic [31:0] d, e;
	} flp_row_t;
	logic         clk_i = 1'b0, rst_i = 1'b1, protect = 1'b0;
	logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0]   adr = 8'h00, track, wave;
	logic [3:0]   sel = 4'h0;
	logic [31:0]  dat = 32'h0000_0000, rd, q;
	flp_drv_out_t drv_o;
	flp_drv_in_t  drv_i;
	int           num_errors = 0, checks_done = 0, ticks = 0;
	int           n, t0, tg = 0, tf = 0;
	flp_row_t     rows [8] = '{
		'{1'h1, REG_CTRL, 4'hf, 32'h0000_0018, 32'h0000_0000},
		'{1'h0, REG_CTRL, 4'hf, 32'h0000_0000, 32'h0000_0018},
		'{1'h1, REG_CTRL, 4'h0, 32'h0000_0001, 32'h0000_0000},
		'{1'h0, REG_CTRL, 4'hf, 32'h0000_0000, 32'h0000_0018},
		'{1'h1, 8'h20,    4'hf, 32'h0000_00ff, 32'h0000_0000},
		'{1'h0, 8'h20,    4'hf, 32'h0000_0000, 32'h0000_0000},
		'{1'h0, REG_CNT,  4'hf, 32'h0000_0000, 32'h0000_0000},
		'{1'h0, REG_SEEK, 4'hf, 32'h0000_0000, 32'h0000_0000}};

	always #20 clk_i = ~clk_i;
	flp_host #(.SPIN_CYC(SPIN), .SETTLE_CYC(SETTLE), .STEP_GAP(GAP),
		.TRIM_CYC(TRIM)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.drv_o(drv_o), .drv_i(drv_i));
	flp_drv_model #(.TRIM(TRIM)) drive_u (.clk_i(clk_i),
		.protect_i(protect), .pins_i(drv_o), .pins_o(drv_i),
		.track_o(track), .wave_o(wave));
	// first flux delay from the gate
	always @(negedge drv_o.record_gate_n)
		tg = ticks;
	always @(negedge drv_o.record_flux_n)
		if (tf == 0)
			tf = ticks - tg;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// classic cycle; waits on ack, the timeout guards a hang
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hf);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rd;
		{cyc, stb} <= 2'h0;
	endtask
	// poll one status bit, at most lim reads
	task automatic poll(input int b, input logic v, input int lim);
		n = 0;
		do
		begin
			wb(1'h0, REG_STAT, 32'h0000_0000);
			n++;
		end
		while (q[b] !== v && n < lim);
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// hang guard, well above the expected run
	always @(posedge clk_i)
	begin
		ticks <= ticks + 1;
		if (ticks == 40000)
		begin
			num_errors++;
			summarize();
		end
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clk_i);
		chk("idle pins", DRV_IDLE, drv_o);
		rst_i <= 1'b0;
		foreach (rows[i])
		begin
			wb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
			if (!rows[i].w)
				chk("register", rows[i].e, q);
		end
		chk("head line", 1'h0, drv_o.head_choice_n);
		chk("selects", 4'he, drv_o.unit_pick_n);
		chk("motor idle", 1'h1, drv_o.motor_on_n);
		// spin up
		wb(1'h1, REG_CTRL, 32'h0000_0009);
		t0 = ticks;
		wb(1'h0, REG_STAT, 32'h0000_0000);
		chk("motor line", 1'h0, drv_o.motor_on_n);
		chk("spin early", 1'h0, q[0]);
		poll(0, 1'b1, 200);
		chk("spin time", 1'h1, ticks - t0 >= SPIN);
		// seek in three, then out past home
		t0 = ticks;
		wb(1'h1, REG_SEEK, 32'h0000_0083);
		poll(5, 1'b0, 200);
		chk("track in", 8'h03, track);
		poll(1, 1'b1, 200);
		chk("settle", 1'h1, ticks - t0 >= 2 * GAP + SETTLE);
		wb(1'h1, REG_SEEK, 32'h0000_0005);
		poll(5, 1'b0, 300);
		poll(1, 1'b1, 200);
		chk("track out", 8'h00, track);
		chk("home flag", 1'h1, q[6]);
		// write three flux pulses, seek refused meanwhile
		wb(1'h1, REG_CTRL, 32'h0000_0029);
		// one pulse queues at a time, so wait for each to leave
		repeat (3)
		begin
			wb(1'h1, REG_FLUX, 32'h0000_0000);
			poll(9, 1'b0, 100);
		end
		wb(1'h1, REG_SEEK, 32'h0000_0081);
		chk("gate", 1'h0, drv_o.record_gate_n);
		poll(9, 1'b0, 100);
		chk("seek refused", 8'h00, track);
		chk("flips", 8'h03, wave);
		chk("first flux", 1'h1, tf >= FIRST_MIN_CYC && tf <= FIRST_MAX_CYC);
		wb(1'h1, REG_CTRL, 32'h0000_0009);
		t0 = ticks;
		poll(3, 1'b1, 2000);
		chk("tail pulse", 8'h04, wave);
		chk("gate off", 1'h1, drv_o.record_gate_n);
		chk("recovery", 1'h1, ticks - t0 >= TRIM + 2500);
		repeat (600) @(posedge clk_i);
		wb(1'h0, REG_CNT, 32'h0000_0000);
		chk("read pulses", 1'h1, q[15:0] != 16'h0000);
		chk("holes", 1'h1, q[31:16] != 16'h0000);
		// locked media
		protect <= 1'b1;
		wb(1'h1, REG_CTRL, 32'h0000_0029);
		poll(7, 1'b1, 20);
		chk("locked", 1'h1, q[7]);
		chk("no gate", 1'h1, drv_o.record_gate_n);
		protect <= 1'b0;
		// power save: deselect, reselect, re-home
		wb(1'h1, REG_CTRL, 32'h0000_0041);
		@(posedge clk_i); // select pins lag the write by a cycle
		chk("deselect", 4'hf, drv_o.unit_pick_n);
		wb(1'h1, REG_CTRL, 32'h0000_0049);
		wb(1'h0, REG_STAT, 32'h0000_0000);
		chk("recal set", 1'h1, q[8]);
		wb(1'h1, REG_SEEK, 32'h0000_0002);
		poll(5, 1'b0, 300);
		poll(8, 1'b0, 300);
		chk("recal done", 1'h1, q[6]);
		// mid-run reset drops every line back to idle
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("reset pins", DRV_IDLE, drv_o);
		rst_i <= 1'b0;
		wb(1'h0, REG_CTRL, 32'h0000_0000);
		chk("reset ctrl", 32'h0000_0000, q);
		summarize();
	end
endmodule
`default_nettype wire
